// File: dv/dus_remote.sv
`timescale 1ns/10ps
module dus_remote #(
   parameter int BIT_CYCLES = 4
) (
   // clock
   input  wire logic        clock,
   // device pin drive
   input  wire logic [15:0] gpio_out,
   input  wire logic [15:0] gpio_oe,
   // resolved pin levels
   output logic      [15:0] gpio_in
);
   logic [15:0] drv_en;  // remote drives this pin
   logic [15:0] drv_val; // level the remote drives

   initial begin
      drv_en = 16'h0000;
      drv_val = 16'hffff;
   end

   // released pins float to the pull-up, so a line never shows a stale value
   always_comb begin
      for (int i = 0; i < 16; i++)
         gpio_in[i] = gpio_oe[i] ? gpio_out[i] : (drv_en[i] ? drv_val[i] : 1'b1);
   end

   // remote takes or releases one pin, e.g. the clear-to-send input
   task automatic set_pin(input int pin, input logic drive, input logic val);
      drv_en[pin] = drive;
      drv_val[pin] = val;
   endtask

   // low start, lsb first, chosen stop level, then release to idle high
   task automatic send_byte(input int pin, input logic [7:0] data, input logic stop);
      logic [9:0] frame;
      frame = {stop, data, 1'b0};
      for (int b = 0; b < 10; b++) begin
         set_pin(pin, 1'b1, frame[b]);
         repeat (BIT_CYCLES) @(posedge clock);
         #2;
      end
      set_pin(pin, 1'b0, 1'b1);
   endtask

   // waits a bounded time for a start bit, then samples mid-bit
   task automatic catch_byte(input int pin, output logic found, output logic [8:0] got);
      found = 1'b0;
      got = 9'h000;
      for (int n = 0; n < 400 && !found; n++) begin
         @(posedge clock);
         #2;
         if (gpio_in[pin] === 1'b0) found = 1'b1;
      end
      if (found) begin
         repeat (BIT_CYCLES / 2) @(posedge clock);
         for (int b = 0; b < 9; b++) begin
            repeat (BIT_CYCLES) @(posedge clock);
            #1;
            got[b] = gpio_in[pin];
         end
      end
   endtask
endmodule

// File: dv/dus_top_tb.sv
`timescale 1ns/10ps
module dus_top_tb;
   localparam int BITS = 4; // shortened bit time keeps the run brief
   logic                 clock;
   logic                 reset;
   logic                 en_valid;
   dus_pkg::dus_en_req_t en_req;
   logic                 dis_valid;
   logic [1:0]           dis_port;
   logic [1:0]           alt_loc;
   logic                 p0_two_wire;
   logic                 p1_one_wire;
   logic                 clk16_ready;
   logic                 wr_valid;
   dus_pkg::dus_wr_t     wr_req;
   logic [15:0]          gpio_in;
   logic [15:0]          gpio_out;
   logic [15:0]          gpio_oe;
   logic [1:0]           port_en;
   logic                 en_ok;
   logic                 en_fail;
   logic                 wr_fault;
   logic                 jtag_en;
   logic [1:0][10:0]     tx_cap;
   logic [1:0][10:0]     rx_cap;
   logic [1:0]           tx_busy;
   logic [1:0]           rx_valid;
   logic [1:0]           frame_err;
   logic [1:0][7:0]      rx_data;
   int                   err_total;
   int                   comparisons;

   dus_top #(.BIT_CYCLES(BITS)) DUT (.clock(clock), .reset(reset), .en_valid(en_valid), .en_req(en_req),
      .dis_valid(dis_valid), .dis_port(dis_port), .alt_loc(alt_loc), .p0_two_wire(p0_two_wire),
      .p1_one_wire(p1_one_wire), .clk16_ready(clk16_ready), .wr_valid(wr_valid), .wr_req(wr_req),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .port_en(port_en), .en_ok(en_ok),
      .en_fail(en_fail), .wr_fault(wr_fault), .jtag_en(jtag_en), .tx_cap(tx_cap), .rx_cap(rx_cap),
      .tx_busy(tx_busy), .rx_valid(rx_valid), .frame_err(frame_err), .rx_data(rx_data));

   dus_remote #(.BIT_CYCLES(BITS)) u_remote (.clock(clock), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .gpio_in(gpio_in));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic give_verdict;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic timeout_hit;
      err_total++;
      give_verdict();
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      comparisons++;
      if (seen !== expv) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
      end
   endtask

   // inputs move 2 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask

   task automatic enable(input logic [1:0] p, input logic txp, input logic [10:0] txl, input logic rxp,
                         input logic [10:0] rxl, input logic ok);
      en_req = '{p, txp, txl, rxp, rxl};
      en_valid = 1'b1;
      tick(1);
      en_valid = 1'b0;
      // result pulse stands for one cycle only, so look at it now
      check({14'h0, en_ok, en_fail}, {14'h0, ok, !ok});
      tick(1);
   endtask

   task automatic write_byte(input logic [1:0] p, input logic [7:0] d, input logic fault);
      wr_req = '{p, d};
      wr_valid = 1'b1;
      tick(1);
      wr_valid = 1'b0;
      // exception pulse stands for one cycle only
      check({15'h0, wr_fault}, {15'h0, fault});
      tick(1);
   endtask

   // port off, then pins and debug port handed back
   task automatic dis_op(input logic [1:0] p);
      dis_port = p;
      dis_valid = 1'b1;
      tick(1);
      dis_valid = 1'b0;
      tick(2);
      check({14'h0, port_en}, 16'h0000);
      check(gpio_oe, 16'h0000);
      check({15'h0, jtag_en}, 16'h0001);
      write_byte(p, 8'h11, 1'b1);
   endtask

   task automatic expect_frame(input int pin, input logic [1:0] p, input logic [7:0] d);
      logic       found;
      logic [8:0] got;
      u_remote.catch_byte(pin, found, got);
      if (!found) timeout_hit();
      check({7'h0, got}, {7'h0, 1'b1, d});
      for (int n = 0; n < 50 && tx_busy[p] !== 1'b0; n++) tick(1);
      check({15'h0, tx_busy[p]}, 16'h0000);
   endtask

   // bounded watch for a receive result on one port
   task automatic watch_rx(input logic p, output logic [1:0] seen, output logic [7:0] d);
      seen = 2'b00;
      d = 8'h00;
      for (int n = 0; n < 100 && seen == 2'b00; n++) begin
         @(posedge clock);
         #1;
         seen = {frame_err[p], rx_valid[p]};
         d = rx_data[p];
      end
      if (seen == 2'b00) timeout_hit();
   endtask

   task automatic sc_refusals;
      check({13'h0, jtag_en, port_en}, 16'h0004);
      write_byte(2'h0, 8'h55, 1'b1);
      write_byte(2'h3, 8'h55, 1'b1);
      enable(2'h2, 1'b1, 11'h010, 1'b1, 11'h010, 1'b0);
      enable(2'h1, 1'b0, 11'h010, 1'b1, 11'h010, 1'b0);
      enable(2'h1, 1'b1, 11'h00f, 1'b1, 11'h010, 1'b0);
      clk16_ready = 1'b0;
      enable(2'h1, 1'b1, 11'h010, 1'b0, 11'h000, 1'b0);
      clk16_ready = 1'b1;
      check({14'h0, port_en}, 16'h0000);
   endtask

   // default four-wire: held clear-to-send stalls the transmitter
   task automatic sc_four_wire;
      logic [1:0] seen;
      logic [7:0] d;
      u_remote.set_pin(4, 1'b1, 1'b1);
      enable(2'h0, 1'b1, 11'h010, 1'b1, 11'h7ff, 1'b1);
      check({5'h0, tx_cap[0]}, 16'h0010);
      check({5'h0, rx_cap[0]}, 16'h07ff);
      tick(1);
      check({15'h0, jtag_en}, 16'h0000);
      check(gpio_oe & 16'hf0f0, 16'h0060);
      check({14'h0, gpio_out[6:5]}, 16'h0002);
      write_byte(2'h0, 8'ha5, 1'b0);
      write_byte(2'h1, 8'ha5, 1'b1);
      // busy port: byte dropped, no exception, frame below stays a5
      write_byte(2'h0, 8'h0f, 1'b0);
      tick(20);
      check({14'h0, gpio_in[6], tx_busy[0]}, 16'h0003);
      u_remote.set_pin(4, 1'b1, 1'b0);
      expect_frame(6, 2'h0, 8'ha5);
      u_remote.set_pin(4, 1'b0, 1'b1);
      // port zero receive on its primary pin
      fork
         u_remote.send_byte(7, 8'hc3, 1'b1);
         watch_rx(1'b0, seen, d);
      join
      check({6'h0, seen, d}, 16'h01c3);
      dis_op(2'h0);
   endtask

   // alternate pins, two-wire, no receive buffer: handshake ignored
   task automatic sc_two_wire_alt;
      alt_loc = 2'b01;
      p0_two_wire = 1'b1;
      u_remote.set_pin(12, 1'b1, 1'b1);
      enable(2'h0, 1'b1, 11'h7ff, 1'b0, 11'h005, 1'b1);
      check({5'h0, rx_cap[0]}, 16'h0000);
      tick(1);
      check(gpio_oe, 16'h4000);
      write_byte(2'h0, 8'h3c, 1'b0);
      expect_frame(14, 2'h0, 8'h3c);
      u_remote.set_pin(12, 1'b0, 1'b1);
      dis_op(2'h0);
      p0_two_wire = 1'b0;
   endtask

   task automatic sc_port_one;
      logic [1:0] seen;
      logic [7:0] d;
      alt_loc = 2'b00;
      enable(2'h1, 1'b1, 11'h010, 1'b1, 11'h010, 1'b1);
      tick(1);
      check({15'h0, jtag_en}, 16'h0001);
      check(gpio_oe, 16'h4000);
      fork
         u_remote.send_byte(15, 8'h96, 1'b1);
         watch_rx(1'b1, seen, d);
      join
      check({6'h0, seen, d}, 16'h0196);
      fork
         u_remote.send_byte(15, 8'h3d, 1'b0);
         watch_rx(1'b1, seen, d);
      join
      check({14'h0, seen}, 16'h0002);
      write_byte(2'h1, 8'h81, 1'b0);
      expect_frame(14, 2'h1, 8'h81);
      dis_op(2'h1);
   endtask

   // alternate pins, one-wire: only the transmit pin is driven
   task automatic sc_one_wire_alt;
      alt_loc = 2'b10;
      p1_one_wire = 1'b1;
      enable(2'h1, 1'b1, 11'h010, 1'b0, 11'h000, 1'b1);
      tick(1);
      check(gpio_oe, 16'h0800);
      write_byte(2'h1, 8'h5a, 1'b0);
      expect_frame(11, 2'h1, 8'h5a);
      dis_op(2'h1);
   endtask

   initial begin
      err_total = 0;
      comparisons = 0;
      reset = 1'b1;
      en_valid = 1'b0;
      en_req = '0;
      dis_valid = 1'b0;
      dis_port = 2'h0;
      alt_loc = 2'b00;
      p0_two_wire = 1'b0;
      p1_one_wire = 1'b0;
      clk16_ready = 1'b1;
      wr_valid = 1'b0;
      wr_req = '0;
      tick(4);
      reset = 1'b0;
      sc_refusals();
      sc_four_wire();
      sc_two_wire_alt();
      sc_port_one();
      sc_one_wire_alt();
      give_verdict();
   end

   // hang guard
   initial begin
      #2000000;
      timeout_hit();
   end
endmodule

// File: rtl/dus_pkg.sv
`include "dus_regs.svh"
package dus_pkg;
   // enable request from software
   typedef struct packed {
      logic [1:0]            port;
      logic                  tx_present;
      logic [`DUS_LEN_W-1:0] tx_len;
      logic                  rx_present;
      logic [`DUS_LEN_W-1:0] rx_len;
   } dus_en_req_t;
   // transmit data write
   typedef struct packed {
      logic [1:0] port;
      logic [7:0] data;
   } dus_wr_t;
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} dus_tx_st_t;
   typedef enum logic {RX_IDLE, RX_RUN} dus_rx_st_t;
endpackage

// File: rtl/dus_regs.svh
`ifndef DUS_REGS_SVH
`define DUS_REGS_SVH
// buffer size field width and permitted range
`define DUS_LEN_W      11
`define DUS_LEN_MIN    11'h010
`define DUS_LEN_MAX    11'h7ff
// port identities
`define DUS_ID_ZERO    2'h0
`define DUS_ID_ONE     2'h1
// port zero pins, primary then alternate
`define DUS_P0_CTS     4'h4
`define DUS_P0_RTS     4'h5
`define DUS_P0_TX      4'h6
`define DUS_P0_RX      4'h7
`define DUS_P0_CTS_ALT 4'hc
`define DUS_P0_RTS_ALT 4'hd
`define DUS_P0_TX_ALT  4'he
`define DUS_P0_RX_ALT  4'hf
// port one pins, primary then alternate
`define DUS_P1_TX      4'he
`define DUS_P1_RX      4'hf
`define DUS_P1_TX_ALT  4'hb
`define DUS_P1_RX_ALT  4'h9
// frame: start, eight data, stop
`define DUS_LAST_BIT   4'h9
`endif

// File: rtl/dus_top.sv
`timescale 1ns/10ps
`include "dus_regs.svh"
module dus_top #(
   parameter int BIT_CYCLES = 40
) (
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         reset,
   // enable and disable requests
   input  wire logic                         en_valid,
   input  wire dus_pkg::dus_en_req_t         en_req,
   input  wire logic                         dis_valid,
   input  wire logic [1:0]                   dis_port,
   // setup levels, sampled at enable
   input  wire logic [1:0]                   alt_loc,
   input  wire logic                         p0_two_wire,
   input  wire logic                         p1_one_wire,
   input  wire logic                         clk16_ready,
   // transmit writes
   input  wire logic                         wr_valid,
   input  wire dus_pkg::dus_wr_t             wr_req,
   // general io pins
   input  wire logic [15:0]                  gpio_in,
   output logic [15:0]                       gpio_out,
   output logic [15:0]                       gpio_oe,
   // status and results
   output logic [1:0]                        port_en,
   output logic                              en_ok,
   output logic                              en_fail,
   output logic                              wr_fault,
   output logic                              jtag_en,
   output logic [1:0][`DUS_LEN_W-1:0]        tx_cap,
   output logic [1:0][`DUS_LEN_W-1:0]        rx_cap,
   // per-port engine outputs
   output logic [1:0]                        tx_busy,
   output logic [1:0]                        rx_valid,
   output logic [1:0]                        frame_err,
   output logic [1:0][7:0]                   rx_data
);
   localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);  // last cycle of a bit
   localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);  // start offset for mid-bit sampling
   logic [1:0] loc_r;       // alternate location latched at enable
   logic       fourw_r;     // port zero four-wire latched at enable
   logic       onew_r;      // port one one-wire latched at enable
   logic [1:0] rxen_r;      // receive buffer given at enable
   logic       en_bad;      // enable request must be refused
   logic [1:0] wr_go;       // write accepted per port
   logic [1:0] txd_w;       // serial out per port
   logic [1:0] rxd_w;       // serial in per port, high when unused
   logic [1:0] cts_n_w;     // clear-to-send, low = go
   logic [1:0] rx_on;       // receiver allowed to run
   logic       rts_n_w;     // port zero request-to-send, low = ready
   logic [15:0] out_nxt;
   logic [15:0] oe_nxt;
   logic        wr_id_ok;
   // enable check: id, buffer presence, size, clock
   always_comb begin
      en_bad = (en_req.port > `DUS_ID_ONE) || !en_req.tx_present ||
               (en_req.tx_len < `DUS_LEN_MIN) || (en_req.tx_len > `DUS_LEN_MAX) ||
               !clk16_ready;
   end
   // port enables; enable wins over a disable in the same cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         port_en <= 2'h0;
      end else begin
         if (dis_valid && dis_port <= `DUS_ID_ONE) begin
            port_en[dis_port[0]] <= 1'b0;
         end
         if (en_valid && !en_bad) begin
            port_en[en_req.port[0]] <= 1'b1;
         end
      end
   end
   // setup sampled only at enable, so later changes have no effect
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         loc_r   <= 2'h0;
         fourw_r <= 1'b1;
         onew_r  <= 1'b0;
         rxen_r  <= 2'h0;
         tx_cap  <= '0;
         rx_cap  <= '0;
      end else if (en_valid && !en_bad) begin
         loc_r[en_req.port[0]]  <= alt_loc[en_req.port[0]];
         rxen_r[en_req.port[0]] <= en_req.rx_present;
         tx_cap[en_req.port[0]] <= en_req.tx_len;
         // absent receive buffer: its size is ignored
         rx_cap[en_req.port[0]] <= en_req.rx_present ? en_req.rx_len : '0;
         if (en_req.port == `DUS_ID_ZERO) begin
            fourw_r <= !p0_two_wire;
         end else begin
            onew_r <= p1_one_wire;
         end
      end
   end
   // enable result pulses and debug port ownership
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         en_ok   <= 1'b0;
         en_fail <= 1'b0;
         jtag_en <= 1'b1;
      end else begin
         en_ok   <= en_valid && !en_bad;
         en_fail <= en_valid && en_bad;
         jtag_en <= !port_en[0];  // shared pins
      end
   end
   // write acceptance; a write to a busy port is dropped silently
   always_comb begin
      wr_id_ok = wr_req.port <= `DUS_ID_ONE;
      wr_go    = 2'h0;
      if (wr_valid && wr_id_ok && port_en[wr_req.port[0]] && !tx_busy[wr_req.port[0]]) begin
         wr_go[wr_req.port[0]] = 1'b1;
      end
   end
   // exception on write to a port not enabled
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wr_fault <= 1'b0;
      end else begin
         wr_fault <= wr_valid && (!wr_id_ok || !port_en[wr_req.port[0]]);
      end
   end
   // pin routing; port zero wins where its alternate set overlaps port one's primary pins
   always_comb begin
      out_nxt = 16'h0000;
      oe_nxt  = 16'h0000;
      if (port_en[1]) begin
         out_nxt[loc_r[1] ? `DUS_P1_TX_ALT : `DUS_P1_TX] = txd_w[1];
         oe_nxt[loc_r[1] ? `DUS_P1_TX_ALT : `DUS_P1_TX]  = 1'b1;
      end
      if (port_en[0]) begin
         out_nxt[loc_r[0] ? `DUS_P0_TX_ALT : `DUS_P0_TX] = txd_w[0];
         oe_nxt[loc_r[0] ? `DUS_P0_TX_ALT : `DUS_P0_TX]  = 1'b1;
         if (fourw_r) begin
            out_nxt[loc_r[0] ? `DUS_P0_RTS_ALT : `DUS_P0_RTS] = rts_n_w;
            oe_nxt[loc_r[0] ? `DUS_P0_RTS_ALT : `DUS_P0_RTS]  = 1'b1;
         end
      end
   end
   // input selection; unused receive reads idle high
   always_comb begin
      rx_on[0]   = port_en[0] && rxen_r[0];
      rx_on[1]   = port_en[1] && rxen_r[1] && !onew_r;  // receive pin released
      rxd_w[0]   = rx_on[0] ? gpio_in[loc_r[0] ? `DUS_P0_RX_ALT : `DUS_P0_RX] : 1'b1;
      rxd_w[1]   = rx_on[1] ? gpio_in[loc_r[1] ? `DUS_P1_RX_ALT : `DUS_P1_RX] : 1'b1;
      // without handshake the far end is always clear
      cts_n_w[0] = fourw_r ? gpio_in[loc_r[0] ? `DUS_P0_CTS_ALT : `DUS_P0_CTS] : 1'b0;
      cts_n_w[1] = 1'b0;
      rts_n_w    = !rx_on[0];
   end
   // pins registered so every output comes from a flop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         gpio_out <= 16'h0000;
         gpio_oe  <= 16'h0000;
      end else begin
         gpio_out <= out_nxt;
         gpio_oe  <= oe_nxt;
      end
   end
   // one transmit and receive engine per port
   for (genvar p = 0; p < 2; p++) begin : g_port
      dus_pkg::dus_tx_st_t tx_st_r;
      dus_pkg::dus_rx_st_t rx_st_r;
      logic [9:0]  tsh_r;    // start, data lsb first, stop
      logic [15:0] tcnt_r;
      logic [3:0]  tbit_r;
      logic        txd_r;
      logic        busy_r;
      logic [7:0]  rsh_r;
      logic [15:0] rcnt_r;
      logic [3:0]  rbit_r;
      logic        rv_r;
      logic        fe_r;
      assign txd_w[p]     = txd_r;
      assign tx_busy[p]   = busy_r;
      assign rx_valid[p]  = rv_r;
      assign frame_err[p] = fe_r;
      assign rx_data[p]   = rsh_r;
      // transmitter; disabling powers it down mid-frame
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            tx_st_r <= dus_pkg::TX_IDLE;
            tsh_r   <= 10'h3ff;
            tcnt_r  <= 16'h0000;
            tbit_r  <= 4'h0;
            txd_r   <= 1'b1;
            busy_r  <= 1'b0;
         end else if (!port_en[p]) begin
            tx_st_r <= dus_pkg::TX_IDLE;
            txd_r   <= 1'b1;
            busy_r  <= 1'b0;
         end else begin
            unique case (tx_st_r)
               dus_pkg::TX_IDLE: begin
                  txd_r <= 1'b1;  // line idles high
                  if (wr_go[p]) begin
                     tsh_r   <= {1'b1, wr_req.data, 1'b0};
                     busy_r  <= 1'b1;
                     tx_st_r <= dus_pkg::TX_WAIT;
                  end
               end
               dus_pkg::TX_WAIT: begin
                  // hold the frame until the far end is clear
                  if (!cts_n_w[p]) begin
                     txd_r   <= tsh_r[0];
                     tsh_r   <= {1'b1, tsh_r[9:1]};
                     tcnt_r  <= 16'h0000;
                     tbit_r  <= 4'h0;
                     tx_st_r <= dus_pkg::TX_SHIFT;
                  end
               end
               dus_pkg::TX_SHIFT: begin
                  if (tcnt_r == BIT_LAST) begin
                     tcnt_r <= 16'h0000;
                     if (tbit_r == `DUS_LAST_BIT) begin
                        busy_r  <= 1'b0;
                        txd_r   <= 1'b1;
                        tx_st_r <= dus_pkg::TX_IDLE;
                     end else begin
                        tbit_r <= tbit_r + 4'h1;
                        txd_r  <= tsh_r[0];
                        tsh_r  <= {1'b1, tsh_r[9:1]};
                     end
                  end else begin
                     tcnt_r <= tcnt_r + 16'h0001;
                  end
               end
               default: tx_st_r <= dus_pkg::TX_IDLE;
            endcase
         end
      end
      // receiver samples mid-bit; a high start bit is a glitch
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            rx_st_r <= dus_pkg::RX_IDLE;
            rsh_r   <= 8'h00;
            rcnt_r  <= 16'h0000;
            rbit_r  <= 4'h0;
            rv_r    <= 1'b0;
            fe_r    <= 1'b0;
         end else begin
            rv_r <= 1'b0;
            fe_r <= 1'b0;
            if (!rx_on[p]) begin
               rx_st_r <= dus_pkg::RX_IDLE;
            end else begin
               unique case (rx_st_r)
                  dus_pkg::RX_IDLE: begin
                     if (!rxd_w[p]) begin
                        rcnt_r  <= BIT_HALF;
                        rbit_r  <= 4'h0;
                        rx_st_r <= dus_pkg::RX_RUN;
                     end
                  end
                  dus_pkg::RX_RUN: begin
                     if (rcnt_r == BIT_LAST) begin
                        rcnt_r <= 16'h0000;
                        rbit_r <= rbit_r + 4'h1;
                        if (rbit_r == 4'h0 && rxd_w[p]) begin
                           rx_st_r <= dus_pkg::RX_IDLE;
                        end else if (rbit_r == `DUS_LAST_BIT) begin
                           rv_r    <= rxd_w[p];
                           fe_r    <= !rxd_w[p];  // stop must be high
                           rx_st_r <= dus_pkg::RX_IDLE;
                        end else if (rbit_r != 4'h0) begin
                           rsh_r <= {rxd_w[p], rsh_r[7:1]};  // lsb first
                        end
                     end else begin
                        rcnt_r <= rcnt_r + 16'h0001;
                     end
                  end
               endcase
            end
         end
      end
      AST_TX_START_LOW: assert property (@(posedge clock) disable iff (reset)
         tx_st_r == dus_pkg::TX_WAIT && !cts_n_w[p] && port_en[p] |=> !txd_r && busy_r)
         else $error("start bit not driven low");
      AST_CAP_RANGE: assert property (@(posedge clock) disable iff (reset)
         port_en[p] |-> tx_cap[p] >= `DUS_LEN_MIN)
         else $error("enabled port with undersized buffer");
   end
   AST_EN_FAIL_LEN: assert property (@(posedge clock) disable iff (reset)
      en_valid && en_req.tx_len < `DUS_LEN_MIN |=> en_fail && !en_ok)
      else $error("short buffer not refused");
   AST_EN_CLOCK: assert property (@(posedge clock) disable iff (reset)
      en_valid && !clk16_ready |=> en_fail)
      else $error("enable accepted without clock");
   AST_EN_OK: assert property (@(posedge clock) disable iff (reset)
      en_valid && !en_bad |=> en_ok && port_en[$past(en_req.port[0])])
      else $error("valid enable not taken");
   AST_WR_FAULT: assert property (@(posedge clock) disable iff (reset)
      wr_valid && wr_req.port <= `DUS_ID_ONE && !port_en[wr_req.port[0]] |=> wr_fault)
      else $error("write to disabled port not flagged");
   AST_JTAG_OFF: assert property (@(posedge clock) disable iff (reset)
      $rose(port_en[0]) |=> !jtag_en)
      else $error("debug port kept with port zero on");
   AST_DISABLE: assert property (@(posedge clock) disable iff (reset)
      dis_valid && dis_port <= `DUS_ID_ONE && !en_valid |=> !port_en[$past(dis_port[0])] ##1 !tx_busy[$past(dis_port[0], 2)])
      else $error("disable did not power down");
   AST_P0_TX_PIN: assert property (@(posedge clock) disable iff (reset)
      port_en[0] && loc_r[0] |=> gpio_oe[`DUS_P0_TX_ALT] && !gpio_oe[`DUS_P0_TX])
      else $error("port zero alternate pin not driven");
   AST_P0_TWO_WIRE: assert property (@(posedge clock) disable iff (reset)
      port_en[0] && !fourw_r |=> !gpio_oe[`DUS_P0_RTS] && !gpio_oe[`DUS_P0_RTS_ALT])
      else $error("handshake pin held in two-wire mode");
   AST_P1_TX_PIN: assert property (@(posedge clock) disable iff (reset)
      port_en[1] && loc_r[1] && !port_en[0] |=> gpio_oe[`DUS_P1_TX_ALT])
      else $error("port one alternate pin not driven");
   AST_P1_ONE_WIRE: assert property (@(posedge clock) disable iff (reset)
      port_en[1] && onew_r |=> !rx_valid[1])
      else $error("one-wire port received data");
   COV_EN_ZERO: cover property (@(posedge clock) disable iff (reset) en_ok ##1 port_en[0]);
   COV_RX_BYTE: cover property (@(posedge clock) disable iff (reset) rx_valid[0]);
   COV_TX_DONE: cover property (@(posedge clock) disable iff (reset) $fell(tx_busy[1]));
endmodule
